// file: hw/ria_pkg.sv
// Constants, register map and state type for the inventory command interpreter
package ria_pkg;
   localparam int         APB_AW          = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL        = 8'h00;
   localparam logic [7:0] OFF_SN_LO       = 8'h04;
   localparam logic [7:0] OFF_SN_HI       = 8'h08;
   localparam logic [7:0] OFF_INFO        = 8'h0C;
   localparam logic [7:0] OFF_STATUS      = 8'h10;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0001;
   localparam logic [31:0] SN_RST         = 32'h0000_0000;
   localparam logic [31:0] INFO_RST       = 32'h0000_0000;
   localparam int         CTRL_EN_BIT     = 0;
   localparam int         CTRL_WAKE_BIT   = 1;
   // Request flag positions (bit 1 of the byte is index 0)
   localparam int         FLG_SUBC        = 0;
   localparam int         FLG_RATE        = 1;
   localparam int         FLG_INV         = 2;
   localparam int         FLG_FAMILY      = 4;
   localparam int         FLG_SLOTS       = 5;
   localparam int         FLG_SEL         = 4;
   localparam int         FLG_ADDR        = 5;
   // Commands and reply
   localparam logic [7:0] CMD_INVENTORY   = 8'h01;
   localparam logic [7:0] CMD_QUIET       = 8'h02;
   localparam logic [7:0] RESP_OK         = 8'h00;
   localparam logic [7:0] FAMILY_ANY      = 8'h00;
   localparam logic [7:0] MASK_MAX_SLOT   = 8'h3C;
   localparam logic [7:0] MASK_MAX_NOSLOT = 8'h40;
   localparam logic [3:0] SLOT_LAST       = 4'hF;
   localparam logic [4:0] QUIET_LEN       = 5'h0A;
   localparam logic [3:0] REPLY_LAST      = 4'h9;
   typedef enum logic [1:0] {RX_IDLE, RX_BODY, RX_EVAL, RX_SLOTS} ria_rx_t;
endpackage

// file: hw/ria_mask_match.sv
// Serial number comparison against the mask pattern, extended by the slot counter
`timescale 1ns/1ns
`default_nettype none
module ria_mask_match (
   input  wire logic [63:0] serial_i,
   input  wire logic [63:0] mask_i,
   input  wire logic [7:0]  mlen_i,
   input  wire logic [3:0]  slot_i,
   input  wire logic        use_slot_i,
   output logic             match_o
);
   logic [8:0]  len_tot;
   logic [63:0] ext;
   logic [63:0] miss;

   // Slot bits sit just above the top mask bit
   assign len_tot = {1'b0, mlen_i} + (use_slot_i ? 9'h004 : 9'h000);
   assign ext     = {60'h0, slot_i} << mlen_i;

   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_bit
         logic pat;
         assign pat     = (9'(g) < {1'b0, mlen_i}) ? mask_i[g] : (ext[g] & use_slot_i);
         assign miss[g] = (9'(g) < len_tot) & (serial_i[g] ^ pat);
      end
   endgenerate

   assign match_o = ~|miss;
endmodule
`default_nettype wire

// file: hw/ria_core.sv
// Inventory and stay-quiet request interpreter with reply generation and APB registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ria_core (
   input  wire logic                      sys_clk_i,
   input  wire logic                      sys_rst_i,
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [ria_pkg::APB_AW-1:0] paddr_i,
   input  wire logic [31:0]               pwdata_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   input  wire logic                      rx_sof_i,
   input  wire logic                      rx_byte_valid_i,
   input  wire logic [7:0]                rx_byte_i,
   input  wire logic                      rx_eof_i,
   input  wire logic                      rx_crc_ok_i,
   input  wire logic                      tx_ready_i,
   output logic                           tx_valid_o,
   output logic      [7:0]                tx_byte_o,
   output logic                           tx_last_o,
   output logic                           tx_high_rate_o,
   output logic                           tx_two_subcarrier_o,
   output logic                           tag_quiet_o
);
   import ria_pkg::*;

   ria_rx_t     st_ff;
   ria_rx_t     nxt_st;
   logic [31:0] ctrl_ff;
   logic [31:0] sn_lo_ff;
   logic [31:0] sn_hi_ff;
   logic [31:0] info_ff;
   logic [31:0] prdata_ff;
   logic [7:0]  flags_ff;
   logic [7:0]  cmd_ff;
   logic [7:0]  fam_ff;
   logic [7:0]  mlen_ff;
   logic [63:0] mask_ff;
   logic [4:0]  bcnt_ff;
   logic        sn_miss_ff;
   logic        quiet_ff;
   logic        discard_ff;
   logic [3:0]  slot_ff;
   logic [3:0]  tx_idx_ff;
   logic        tx_valid_ff;
   logic [7:0]  tx_byte_ff;
   logic        tx_rate_ff;
   logic        tx_sub_ff;

   // Request decoding
   logic [63:0] serial;
   logic [7:0]  own_fam;
   logic        enable;
   logic        fam_on;
   logic        slot_used;
   logic        sof_in;
   logic        byte_in;
   logic        frame_end;
   logic [4:0]  mlen_pos;
   logic [4:0]  mask_k;
   logic [4:0]  mask_nb;
   logic [4:0]  inv_len;
   logic [7:0]  mlen_max;
   logic [2:0]  sn_sel;
   logic [7:0]  sn_byte;
   logic        inv_ok;
   logic        sq_ok;
   logic        fam_ok;
   logic        uid_match;
   logic        qualify;
   logic        slot_eof;
   logic        tx_take;
   logic [3:0]  tx_nxt_idx;

   assign serial    = {sn_hi_ff, sn_lo_ff};
   assign own_fam   = info_ff[15:8];
   assign enable    = ctrl_ff[CTRL_EN_BIT];
   assign fam_on    = flags_ff[FLG_FAMILY];
   assign slot_used = ~flags_ff[FLG_SLOTS];
   assign sof_in    = rx_sof_i & enable;
   assign byte_in   = (st_ff == RX_BODY) & rx_byte_valid_i & ~rx_sof_i;
   assign frame_end = (st_ff == RX_BODY) & rx_eof_i & ~rx_sof_i;

   // Field positions shift by one when the family byte is present
   assign mlen_pos  = 5'h02 + {4'h0, fam_on};
   assign mask_k    = bcnt_ff - mlen_pos - 5'h01;
   assign mask_nb   = 5'((9'(mlen_ff) + 9'h007) >> 3);
   assign inv_len   = mlen_pos + 5'h01 + mask_nb;
   assign mlen_max  = slot_used ? MASK_MAX_SLOT : MASK_MAX_NOSLOT;
   assign sn_sel    = 3'(bcnt_ff - 5'h02);
   assign sn_byte   = serial[{sn_sel, 3'h0} +: 8];

   // Any malformed or corrupted request leaves the tag silent
   assign inv_ok = frame_end & rx_crc_ok_i & ~quiet_ff
                 & (cmd_ff == CMD_INVENTORY) & flags_ff[FLG_INV]
                 & (mlen_ff <= mlen_max) & (bcnt_ff == inv_len);
   assign sq_ok  = frame_end & rx_crc_ok_i & (cmd_ff == CMD_QUIET)
                 & ~flags_ff[FLG_INV] & flags_ff[FLG_ADDR] & ~flags_ff[FLG_SEL]
                 & (bcnt_ff == QUIET_LEN) & ~sn_miss_ff;

   assign fam_ok = ~fam_on | (fam_ff == FAMILY_ANY)
                 | ((fam_ff[3:0] == 4'h0) ? (fam_ff[7:4] == own_fam[7:4])
                                          : (fam_ff == own_fam));

   ria_mask_match u_match (
      .serial_i   (serial),
      .mask_i     (mask_ff),
      .mlen_i     (mlen_ff),
      .slot_i     (slot_ff),
      .use_slot_i (slot_used),
      .match_o    (uid_match)
   );

   assign qualify    = (st_ff == RX_EVAL) & ~sof_in & fam_ok & uid_match;
   assign slot_eof   = (st_ff == RX_SLOTS) & rx_eof_i & ~sof_in;
   assign tx_take    = tx_valid_ff & tx_ready_i;
   assign tx_nxt_idx = tx_idx_ff + 4'h1;

   function automatic logic [7:0] reply_byte(input logic [3:0] idx,
                                             input logic [7:0] fmt,
                                             input logic [63:0] sn);
      logic [2:0] k;
      k = 3'(idx - 4'h2);
      if (idx == 4'h0) begin
         reply_byte = RESP_OK;
      end else if (idx == 4'h1) begin
         reply_byte = fmt;
      end else begin
         reply_byte = sn[{k, 3'h0} +: 8];
      end
   endfunction

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         RX_IDLE: begin
            if (sof_in) nxt_st = RX_BODY;
         end
         RX_BODY: begin
            if (sof_in) begin
               nxt_st = RX_BODY;
            end else if (rx_eof_i) begin
               nxt_st = inv_ok ? RX_EVAL : RX_IDLE;
            end
         end
         RX_EVAL: begin
            if (sof_in) begin
               nxt_st = RX_BODY;
            end else begin
               nxt_st = slot_used ? RX_SLOTS : RX_IDLE;
            end
         end
         RX_SLOTS: begin
            if (sof_in) begin
               nxt_st = RX_BODY;
            end else if (rx_eof_i) begin
               nxt_st = (slot_ff == SLOT_LAST) ? RX_IDLE : RX_EVAL;
            end
         end
         default: nxt_st = RX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) st_ff <= RX_IDLE;
      else st_ff <= nxt_st;
   end

   // Field capture; each byte lands by its position in the frame
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sof_in) begin
         bcnt_ff    <= 5'h00;
         flags_ff   <= 8'h00;
         cmd_ff     <= 8'h00;
         fam_ff     <= 8'h00;
         mlen_ff    <= 8'h00;
         mask_ff    <= 64'h0;
         sn_miss_ff <= 1'b0;
      end else if (byte_in) begin
         if (bcnt_ff != 5'h1F) bcnt_ff <= bcnt_ff + 5'h01;
         if (bcnt_ff == 5'h00) flags_ff <= rx_byte_i;
         if (bcnt_ff == 5'h01) cmd_ff <= rx_byte_i;
         if (bcnt_ff == 5'h02 && fam_on) fam_ff <= rx_byte_i;
         if (bcnt_ff == mlen_pos) mlen_ff <= rx_byte_i;
         // Lowest mask byte arrives first
         if (bcnt_ff > mlen_pos && mask_k < 5'h08) begin
            mask_ff[{mask_k[2:0], 3'h0} +: 8] <= rx_byte_i;
         end
         if (bcnt_ff >= 5'h02 && bcnt_ff < QUIET_LEN && sn_byte != rx_byte_i) begin
            sn_miss_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         slot_ff <= 4'h0;
      end else if (inv_ok) begin
         slot_ff <= 4'h0;
      end else if (slot_eof && slot_ff != SLOT_LAST) begin
         slot_ff <= slot_ff + 4'h1;
      end
   end

   // Entering quiet wins over a software wake in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         quiet_ff   <= 1'b0;
         discard_ff <= 1'b0;
      end else begin
         if (sq_ok) begin
            quiet_ff <= 1'b1;
         end else if (psel_i && penable_i && pwrite_i && paddr_i == OFF_CTRL
                      && pwdata_i[CTRL_WAKE_BIT]) begin
            quiet_ff <= 1'b0;
         end
         if (frame_end) discard_ff <= ~(inv_ok | sq_ok);
      end
   end

   // Reply path: with the CTRL enable bit set, a new frame cuts any reply still going out
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sof_in) begin
         tx_valid_ff <= 1'b0;
         tx_idx_ff   <= 4'h0;
         tx_byte_ff  <= 8'h00;
         tx_rate_ff  <= 1'b0;
         tx_sub_ff   <= 1'b0;
      end else if (qualify) begin
         tx_valid_ff <= 1'b1;
         tx_idx_ff   <= 4'h0;
         tx_byte_ff  <= RESP_OK;
         tx_rate_ff  <= flags_ff[FLG_RATE];
         tx_sub_ff   <= flags_ff[FLG_SUBC];
      end else if (tx_take) begin
         tx_valid_ff <= (tx_idx_ff != REPLY_LAST);
         tx_idx_ff   <= tx_nxt_idx;
         tx_byte_ff  <= reply_byte(tx_nxt_idx, info_ff[7:0], serial);
      end
   end

   assign tx_valid_o          = tx_valid_ff;
   assign tx_byte_o           = tx_byte_ff;
   assign tx_last_o           = tx_valid_ff & (tx_idx_ff == REPLY_LAST);
   assign tx_high_rate_o      = tx_rate_ff;
   assign tx_two_subcarrier_o = tx_sub_ff;
   assign tag_quiet_o         = quiet_ff;

   // APB slave: zero wait states, read data latched in the setup cycle
   logic        apb_setup;
   logic        apb_wr;
   logic        apb_hit;
   logic [31:0] rd_mux;
   logic [31:0] status;

   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr    = psel_i & penable_i & pwrite_i;
   assign apb_hit   = (paddr_i == OFF_CTRL) | (paddr_i == OFF_SN_LO)
                    | (paddr_i == OFF_SN_HI) | (paddr_i == OFF_INFO)
                    | (paddr_i == OFF_STATUS);
   assign status    = {23'h0, discard_ff, slot_ff, 2'h0,
                       (st_ff == RX_EVAL) | (st_ff == RX_SLOTS), quiet_ff};
   assign rd_mux    = (paddr_i == OFF_CTRL)   ? {31'h0, ctrl_ff[CTRL_EN_BIT]} :
                      (paddr_i == OFF_SN_LO)  ? sn_lo_ff :
                      (paddr_i == OFF_SN_HI)  ? sn_hi_ff :
                      (paddr_i == OFF_INFO)   ? {16'h0, info_ff[15:0]} :
                      (paddr_i == OFF_STATUS) ? status : 32'h0;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ctrl_ff   <= CTRL_RST;
         sn_lo_ff  <= SN_RST;
         sn_hi_ff  <= SN_RST;
         info_ff   <= INFO_RST;
         prdata_ff <= 32'h0;
      end else begin
         if (apb_setup) prdata_ff <= rd_mux;
         if (apb_wr && paddr_i == OFF_CTRL) ctrl_ff <= {31'h0, pwdata_i[CTRL_EN_BIT]};
         if (apb_wr && paddr_i == OFF_SN_LO) sn_lo_ff <= pwdata_i;
         if (apb_wr && paddr_i == OFF_SN_HI) sn_hi_ff <= pwdata_i;
         if (apb_wr && paddr_i == OFF_INFO) info_ff <= {16'h0, pwdata_i[15:0]};
      end
   end

   assign prdata_o  = prdata_ff;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~apb_hit;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_sof_cuts_reply: assert property (sof_in |=> !tx_valid_o)
      else $error("reply not cut by new frame");
   a_reply_head_ok: assert property ($rose(tx_valid_o) |-> tx_byte_o == RESP_OK)
      else $error("reply does not open with 00h");
   a_reply_tail_sn: assert property (tx_last_o |-> tx_byte_o == serial[63:56])
      else $error("last reply byte is not top serial byte");
   a_crc_silent: assert property ((frame_end && !rx_crc_ok_i) |=> !tx_valid_o [*2])
      else $error("reply after bad CRC");
   a_quiet_no_inv: assert property ((quiet_ff && frame_end) |=> st_ff != RX_EVAL)
      else $error("quiet tag took inventory");
   a_slot_cleared: assert property (inv_ok |=> slot_ff == 4'h0)
      else $error("slot counter not cleared");
   a_slot_steps: assert property ((slot_eof && slot_ff != SLOT_LAST)
      |=> slot_ff == $past(slot_ff) + 4'h1)
      else $error("slot counter did not step");
   a_rate_select: assert property ($rose(tx_valid_o)
      |-> tx_high_rate_o == $past(flags_ff[FLG_RATE]))
      else $error("reply rate does not follow flag");
   a_subc_select: assert property ($rose(tx_valid_o)
      |-> tx_two_subcarrier_o == $past(flags_ff[FLG_SUBC]))
      else $error("subcarrier does not follow flag");
   a_quiet_entry: assert property (sq_ok |=> quiet_ff && !tx_valid_o)
      else $error("stay-quiet not honoured");
   a_match_gate: assert property ($rose(tx_valid_o) |-> $past(uid_match && fam_ok))
      else $error("reply without qualification");
   a_family_any: assert property ((st_ff == RX_EVAL && !sof_in && uid_match
      && fam_ff == FAMILY_ANY) |=> tx_valid_o)
      else $error("family 00h did not qualify");

   c_reply: cover property ($rose(tx_valid_o));
   c_quiet: cover property (sq_ok);
   c_slot_reply: cover property (slot_eof ##2 $rose(tx_valid_o));
endmodule
`default_nettype wire

// file: sim/ria_reader_model.sv
// Reader model: sends request frames and lone end-of-frames, takes reply bytes
`timescale 1ns/1ns
`default_nettype none
module ria_reader_model (
   input  wire logic       sys_clk_i,
   input  wire logic       slow_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_last_i,
   output logic            rx_sof_o,
   output logic            rx_byte_valid_o,
   output logic [7:0]      rx_byte_o,
   output logic            rx_eof_o,
   output logic            rx_crc_ok_o,
   output logic            tx_ready_o
);
   logic [7:0] reply_q[$];
   logic       last_q[$];
   initial begin
      rx_sof_o = 1'b0;
      rx_byte_valid_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_eof_o = 1'b0;
      rx_crc_ok_o = 1'b0;
   end
   // A slow modulator stalls at random so every reply byte must stand until taken
   always @(posedge sys_clk_i) begin
      if (tx_valid_i && tx_ready_o) begin
         reply_q.push_back(tx_byte_i);
         last_q.push_back(tx_last_i);
      end
      tx_ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
   end
   task automatic end_frame(input logic crc_good);
      rx_eof_o <= 1'b1;
      rx_crc_ok_o <= crc_good;
      @(posedge sys_clk_i);
      rx_eof_o <= 1'b0;
      rx_crc_ok_o <= ~crc_good;
   endtask
   task automatic send_frame(input logic [7:0] bytes[$], input logic crc_good);
      @(posedge sys_clk_i);
      rx_sof_o <= 1'b1;
      @(posedge sys_clk_i);
      rx_sof_o <= 1'b0;
      // Valid stays up across back-to-back bytes, one byte per cycle
      foreach (bytes[i]) begin
         rx_byte_valid_o <= 1'b1;
         rx_byte_o <= bytes[i];
         @(posedge sys_clk_i);
      end
      rx_byte_valid_o <= 1'b0;
      // Stale data is inverted so it never reads as a repeat of the last byte
      rx_byte_o <= ~rx_byte_o;
      end_frame(crc_good);
   endtask
endmodule
`default_nettype wire

// file: sim/rfid_inventory_anticollision_tb.sv
// Self-checking bench for the inventory command interpreter
`timescale 1ns/1ns
`default_nettype none
module rfid_inventory_anticollision_tb;
   import ria_pkg::*;
   logic        sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]  paddr_i, rx_byte, tx_byte, fmt, fam;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic        err, slow, rx_sof, rx_bv, rx_eof, rx_crc, tx_ready, tx_valid;
   logic        tx_last, tx_rate, tx_subc, quiet;
   logic [63:0] sn, m;
   logic [7:0]  req[$], want_q[$];
   logic [7:0]  offs[5] = '{OFF_CTRL, OFF_SN_LO, OFF_SN_HI, OFF_INFO, OFF_STATUS};
   logic [31:0] rstv[5] = '{CTRL_RST, SN_RST, SN_RST, INFO_RST, 32'h0};
   logic [7:0]  fams[5];
   int          mismatches, num_checks, ml;

   ria_core DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_sof_i(rx_sof),
      .rx_byte_valid_i(rx_bv), .rx_byte_i(rx_byte), .rx_eof_i(rx_eof), .rx_crc_ok_i(rx_crc),
      .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_last_o(tx_last),
      .tx_high_rate_o(tx_rate), .tx_two_subcarrier_o(tx_subc), .tag_quiet_o(quiet));
   ria_reader_model rdr (.sys_clk_i(sys_clk_i), .slow_i(slow), .tx_valid_i(tx_valid),
      .tx_byte_i(tx_byte), .tx_last_i(tx_last), .rx_sof_o(rx_sof), .rx_byte_valid_o(rx_bv),
      .rx_byte_o(rx_byte), .rx_eof_o(rx_eof), .rx_crc_ok_o(rx_crc), .tx_ready_o(tx_ready));

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic summarize();
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      num_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do @(posedge sys_clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   function automatic logic [63:0] keep(input int w);
      return (w >= 64) ? '1 : ((64'h1 << w) - 64'h1);
   endfunction
   // Reserved flag bits stay zero and the inventory bit is always set here
   function automatic void build_inv(input logic [7:0] flags, input logic [7:0] f,
                                     input int mlen, input logic [63:0] pat);
      req = {flags | 8'h04, CMD_INVENTORY};
      if (flags[FLG_FAMILY]) req.push_back(f);
      req.push_back(8'(mlen));
      for (int i = 0; i < (mlen + 7) / 8; i++) req.push_back(pat[8*i +: 8]);
   endfunction
   function automatic logic qual(input int mlen, input logic [63:0] pat, input logic [3:0] s,
                                 input logic use_s, input logic ff, input logic [7:0] f);
      logic [63:0] ext;
      ext = use_s ? (pat | (64'(s) << mlen)) : pat;
      if (ff && f != FAMILY_ANY && !((f[3:0] == 4'h0) ? (f[7:4] == fam[7:4]) : (f == fam)))
         return 1'b0;
      return ((sn ^ ext) & keep(mlen + (use_s ? 4 : 0))) == 64'h0;
   endfunction
   task automatic transact(input logic crc, input logic yes, input logic lone);
      rdr.reply_q.delete();
      rdr.last_q.delete();
      if (lone) rdr.end_frame(1'b1);
      else rdr.send_frame(req, crc);
      repeat (3) @(posedge sys_clk_i);
      if (yes) check({tx_rate, tx_subc}, {req[0][FLG_RATE], req[0][FLG_SUBC]});
      for (int k = 0; k < 200 && tx_valid === 1'b1; k++) @(posedge sys_clk_i);
      check(64'(rdr.reply_q.size()), yes ? 64'd10 : 64'd0);
      if (yes) foreach (rdr.reply_q[i]) check(rdr.reply_q[i], want_q[i]);
      if (yes) foreach (rdr.last_q[i]) check(rdr.last_q[i], i == 9);
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk_i);
      mismatches++;
      summarize();
   end
   initial begin
      void'($urandom(32'hF191));
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, slow} = '0;
      sys_rst_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, offs[i], 32'h0);
         check({err, rd}, {1'b0, rstv[i]});
      end
      apb(1'b1, 8'h20, '1);
      check(err, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      sn = {$urandom, $urandom};
      fmt = 8'($urandom);
      fam = 8'($urandom);
      apb(1'b1, OFF_SN_LO, sn[31:0]);
      apb(1'b1, OFF_SN_HI, sn[63:32]);
      apb(1'b1, OFF_INFO, {16'h0, fam, fmt});
      apb(1'b0, OFF_SN_HI, 32'h0);
      check(rd, sn[63:32]);
      want_q = {RESP_OK, fmt};
      for (int i = 0; i < 8; i++) want_q.push_back(sn[8*i +: 8]);
      // Every rate and subcarrier combination, no mask, no slots
      for (int c = 0; c < 4; c++) begin
         build_inv(8'h20 | 8'(c), 8'h0, 0, 64'h0);
         transact(1'b1, 1'b1, 1'b0);
      end
      slow <= 1'b1;
      for (int n = 0; n < 12; n++) begin
         ml = $urandom_range(64, 1);
         m = sn & keep(ml);
         if ($urandom_range(1)) m = m ^ (64'h1 << $urandom_range(ml - 1));
         build_inv(8'h20, 8'h0, ml, m);
         transact(1'b1, qual(ml, m, 4'h0, 1'b0, 1'b0, 8'h0), 1'b0);
      end
      fams = '{fam, FAMILY_ANY, {fam[7:4], 4'h0}, fam ^ 8'h01, {~fam[7:4], 4'h0}};
      foreach (fams[i]) begin
         build_inv(8'h30, fams[i], 0, 64'h0);
         transact(1'b1, qual(0, 64'h0, 4'h0, 1'b0, 1'b1, fams[i]), 1'b0);
      end
      ml = $urandom_range(8, 0);
      m = sn & keep(ml);
      build_inv(8'h00, 8'h0, ml, m);
      for (int s = 0; s < 16; s++)
         transact(1'b1, qual(ml, m, 4'(s), 1'b1, 1'b0, 8'h0), s != 0);
      build_inv(8'h00, 8'h0, 60, sn & keep(60));
      transact(1'b1, qual(60, sn & keep(60), 4'h0, 1'b1, 1'b0, 8'h0), 1'b0);
      // One bit over the slot-mode limit is refused outright
      build_inv(8'h00, 8'h0, 61, sn & keep(61));
      transact(1'b1, 1'b0, 1'b0);
      build_inv(8'h20, 8'h0, 0, 64'h0);
      transact(1'b0, 1'b0, 1'b0);
      // A new frame cuts a stalled reply short
      rdr.reply_q.delete();
      rdr.send_frame(req, 1'b1);
      repeat (3) @(posedge sys_clk_i);
      rdr.send_frame(req, 1'b0);
      check(tx_valid, 1'b0);
      check(rdr.reply_q.size() < 10, 1'b1);
      req = {8'h20, CMD_QUIET};
      for (int i = 0; i < 8; i++) req.push_back(sn[8*i +: 8]);
      transact(1'b1, 1'b0, 1'b0);
      check(quiet, 1'b1);
      build_inv(8'h20, 8'h0, 0, 64'h0);
      transact(1'b1, 1'b0, 1'b0);
      apb(1'b1, OFF_CTRL, 32'h3);
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd[0], 1'b0);
      transact(1'b1, 1'b1, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
